// ### rtl/iscq_regs.vh
/*
  Constants for the status and queue unit: command codes, status byte
  positions, queue sizes and error codes.
  Assumes inclusion by bare name from the design files under rtl/.
*/
// Behaviour
// [R1] Queries of state word, latches and masks return bits 0 through 15.
// [R2] Reading a change latch returns its value then clears it.
// [R3] Mask write loads the value; later read returns it.
// [R4] Settle service request needs rising mask bit 12 and summary enable.
// [R5] Every processed query loads its reply; queue holds at most 800 chars.
// [R6] Reads remove characters; an empty queue gives no reply.
// [R7] Message-available bit is 1 while response queue not empty.
// [R8] Command, execution and device errors append their code to error queue.
// [R9] Error pop returns and removes oldest error, or 0 when empty.
// [R10] Fault-pending bit shows whether the error queue holds entries.
// [R11] Fault-pending bit sits at status byte weight 8.
// [R12] Error queue empties at power loss and on clear-status.
// [R13] Error queue has 16 slots; 15 errors then overflow entry; rest dropped.
// [R14] Commands are processed one at a time in arrival order.
// [R15] Output-enable command refused while errors remain queued.
// [R16] Operation-complete query replies 1 only after output settled.
// [R17] Service-request bit sits at status byte weight 64.
// [R18] Controller should read after every operation-complete query.
// [R19] Controller repeats error pop until it returns 0.
// [R20] Falling latch records 1-to-0 bits; rising latch records 0-to-1.
// [R21] Latched change with mask bit set raises the change summary flag.
// [R22] Latches clear at power-on and clear-status; masks clear at power-up.
// [R23] Removing any error entry makes room for new errors again.
// [R24] Replies enter the response queue in query processing order.
`ifndef ISCQ_REGS_VH
`define ISCQ_REGS_VH

// Command codes on the command port
`define ISCQ_CMD_STATE_RD   4'h0
`define ISCQ_CMD_FLATCH_RD  4'h1
`define ISCQ_CMD_RLATCH_RD  4'h2
`define ISCQ_CMD_FMASK_RD   4'h3
`define ISCQ_CMD_RMASK_RD   4'h4
`define ISCQ_CMD_FMASK_WR   4'h5
`define ISCQ_CMD_RMASK_WR   4'h6
`define ISCQ_CMD_ERR_POP    4'h7
`define ISCQ_CMD_CLS        4'h8
`define ISCQ_CMD_OUTPUT_ENABLE_COMMAND       4'h9
`define ISCQ_CMD_OPC_Q      4'hA

// Status byte positions
`define ISCQ_STB_SUMMARY    2
`define ISCQ_STB_FAULT      3
`define ISCQ_STB_MAV        4
`define ISCQ_STB_RQS        6
`define ISCQ_STB_EVENT      5
`define ISCQ_RQS_MASK       8'hBF

// State word bit for settled output
`define ISCQ_BIT_SETTLED    12

// Queue sizing
`define ISCQ_RQ_DEPTH       800
`define ISCQ_RQ_AW          10
`define ISCQ_EQ_SLOTS       16
`define ISCQ_EQ_KEEP        15
`define ISCQ_EQ_AW          4
`define ISCQ_EQ_CW          5

// Error codes
`define ISCQ_ERR_NONE       16'h0000
`define ISCQ_ERR_OVERFLOW   16'h0001

// Characters
`define ISCQ_CHR_ZERO       8'h30
`define ISCQ_CHR_ONE        8'h31
`define ISCQ_CHR_LF         8'h0A
`define ISCQ_DIGITS         5

`endif

// ### rtl/iscq_mem.v
/*
  Simple dual-port memory for the response queue, registered read.
  Assumes one clock; write and read addresses come from the owner.
*/
`timescale 1ns/10ps
module iscq_mem #(
  parameter DW    = 8,
  parameter AW    = 10,
  parameter DEPTH = 800
) (
  // Clock
  input  wire          mclk,
  // Write side
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // Read side
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ### rtl/iscq_skid.v
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
module iscq_skid #(
  parameter DW = 8
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          rstn,
  // Filling side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [DW-1:0] in_data,
  // Draining side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [DW-1:0] out_data
);
  reg [DW-1:0] slot0;
  reg [DW-1:0] slot1;
  reg [1:0]    count;
  wire         push;
  wire         pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge mclk) begin
    if (!rstn) begin
      count <= 2'h0;
      slot0 <= {DW{1'b0}};
      slot1 <= {DW{1'b0}};
    end else begin
      if (pop) begin
        slot0 <= (count == 2'h2) ? slot1 : in_data;
      end else if (push && count == 2'h0) begin
        slot0 <= in_data;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2))) begin
        slot1 <= in_data;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### rtl/iscq_top.v
/*
  Status and queue unit: state word change latches and masks, response
  queue of characters, error queue and the serial-poll status byte.
  Assumes a command decoder on mclk that presents one command at a time
  with cmd_valid/cmd_ready, and a bus side that drains replies by ready.
*/
`timescale 1ns/10ps
`include "iscq_regs.vh"
module iscq_top #(
  parameter RQ_DEPTH = `ISCQ_RQ_DEPTH,
  parameter EQ_SLOTS = `ISCQ_EQ_SLOTS
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // Command port
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [3:0]  cmd_code,
  input  wire [15:0] cmd_value,
  // Error reports
  input  wire        err_valid,
  input  wire [15:0] err_code,
  // Instrument state
  input  wire [15:0] instrument_condition_word,
  input  wire        output_settled,
  // Service request enable and summary
  input  wire [7:0]  srq_enable,
  input  wire        event_summary,
  // Reply characters to the bus
  output wire        reply_valid,
  input  wire        reply_ready,
  output wire [7:0]  reply_data,
  // Output-enable outcome
  output reg         output_enable_command_accept,
  output reg         output_enable_command_refused,
  // Status byte
  output reg  [7:0]  status_byte,
  output wire        service_request
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CONV = 3'h1;
  localparam ST_EMIT = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_LF   = 3'h4;

  // Condition word is from another domain
  reg  [15:0] cond_s1;
  reg  [15:0] cond_s2;
  reg  [15:0] cond_prev;
  reg  [1:0]  settle_s;
  reg  [15:0] falling_edge_latch;
  reg  [15:0] rising_edge_latch;
  reg  [15:0] falling_edge_mask;
  reg  [15:0] rising_edge_mask;
  reg         rqs;

  reg  [2:0]  state;
  reg  [15:0] conv_val;
  reg  [19:0] bcd;
  reg  [4:0]  bit_cnt;
  reg  [2:0]  dig_idx;
  reg         lead;

  // Error queue
  reg  [15:0]           eq_mem [0:EQ_SLOTS-1];
  reg  [`ISCQ_EQ_AW-1:0] eq_rd;
  reg  [`ISCQ_EQ_AW-1:0] eq_wr;
  reg  [`ISCQ_EQ_CW-1:0] eq_cnt;

  // Response queue
  reg  [`ISCQ_RQ_AW-1:0] rq_wr;
  reg  [`ISCQ_RQ_AW-1:0] rq_rd;
  reg  [`ISCQ_RQ_AW:0]   rq_cnt;
  reg                    rq_wr_en;
  reg  [7:0]             rq_wr_data;
  wire [7:0]             rq_rd_data;
  reg                    mem_vld;
  wire                   skid_ready;
  wire                   rq_full;
  wire                   rq_pop;
  wire                   change_hit;
  wire                   clr;
  wire                   take;

  function [`ISCQ_RQ_AW-1:0] rq_next;
    input [`ISCQ_RQ_AW-1:0] p;
    begin
      rq_next = (p == RQ_DEPTH - 1) ? {`ISCQ_RQ_AW{1'b0}}
                                    : p + 1'b1;
    end
  endfunction

  function is_query;
    input [3:0] c;
    begin
      is_query = (c <= `ISCQ_CMD_RMASK_RD) || (c == `ISCQ_CMD_ERR_POP);
    end
  endfunction

  assign cmd_ready = (state == ST_IDLE); // R14
  assign take      = cmd_valid && cmd_ready;
  assign clr       = take && (cmd_code == `ISCQ_CMD_CLS);
  assign rq_full   = (rq_cnt >= RQ_DEPTH);
  assign rq_pop    = (rq_cnt != 0) && !mem_vld && !rq_wr_en;
  assign change_hit = |((falling_edge_latch & falling_edge_mask) |
                        (rising_edge_latch & rising_edge_mask)); // R21 R4
  assign service_request = status_byte[`ISCQ_STB_RQS];

  always @(posedge mclk) begin
    if (!rstn) begin
      cond_s1   <= 16'h0000;
      cond_s2   <= 16'h0000;
      cond_prev <= 16'h0000;
      settle_s  <= 2'h0;
    end else begin
      cond_s1   <= instrument_condition_word;
      cond_s2   <= cond_s1;
      cond_prev <= cond_s2;
      settle_s  <= {settle_s[0], output_settled};
    end
  end

  // Latches, masks; a change landing on a read-clear still latches
  always @(posedge mclk) begin
    if (!rstn) begin
      falling_edge_latch <= 16'h0000; // R22
      rising_edge_latch  <= 16'h0000;
      falling_edge_mask  <= 16'h0000;
      rising_edge_mask   <= 16'h0000;
    end else begin
      falling_edge_latch <= ((clr || (take && cmd_code ==
        `ISCQ_CMD_FLATCH_RD)) ? 16'h0000 : falling_edge_latch)
        | (cond_prev & ~cond_s2); // R20 R2 R22
      rising_edge_latch <= ((clr || (take && cmd_code ==
        `ISCQ_CMD_RLATCH_RD)) ? 16'h0000 : rising_edge_latch)
        | (~cond_prev & cond_s2); // R20 R2 R22
      if (take && cmd_code == `ISCQ_CMD_FMASK_WR) begin
        falling_edge_mask <= cmd_value; // R3
      end
      if (take && cmd_code == `ISCQ_CMD_RMASK_WR) begin
        rising_edge_mask <= cmd_value; // R3
      end
    end
  end

  // Error queue: first 15 kept, 16th slot overflow, rest dropped
  always @(posedge mclk) begin
    if (!rstn || clr) begin
      eq_rd  <= {`ISCQ_EQ_AW{1'b0}}; // R12
      eq_wr  <= {`ISCQ_EQ_AW{1'b0}};
      eq_cnt <= {`ISCQ_EQ_CW{1'b0}};
    end else begin
      if (err_valid && eq_cnt < EQ_SLOTS) begin
        eq_mem[eq_wr] <= (eq_cnt == EQ_SLOTS - 1) ? `ISCQ_ERR_OVERFLOW
                                                  : err_code; // R8 R13
        eq_wr <= eq_wr + 1'b1;
      end
      if (take && cmd_code == `ISCQ_CMD_ERR_POP && eq_cnt != 0) begin
        eq_rd <= eq_rd + 1'b1; // R9 R23
      end
      eq_cnt <= eq_cnt
        + {4'h0, (err_valid && eq_cnt < EQ_SLOTS)}
        - {4'h0, (take && cmd_code == `ISCQ_CMD_ERR_POP &&
                  eq_cnt != 0)};
    end
  end

  // Query engine: value to decimal characters then line feed
  always @(posedge mclk) begin
    if (!rstn) begin
      state        <= ST_IDLE;
      conv_val     <= 16'h0000;
      bcd          <= 20'h00000;
      bit_cnt      <= 5'h00;
      dig_idx      <= 3'h0;
      lead         <= 1'b1;
      rq_wr_en     <= 1'b0;
      rq_wr_data   <= 8'h00;
      output_enable_command_accept  <= 1'b0;
      output_enable_command_refused <= 1'b0;
    end else begin
      rq_wr_en     <= 1'b0;
      output_enable_command_accept  <= 1'b0;
      output_enable_command_refused <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            bcd     <= 20'h00000;
            bit_cnt <= 5'h00;
            lead    <= 1'b1;
            dig_idx <= 3'h0;
            case (cmd_code)
              `ISCQ_CMD_STATE_RD:  conv_val <= cond_s2; // R1
              `ISCQ_CMD_FLATCH_RD: conv_val <= falling_edge_latch;
              `ISCQ_CMD_RLATCH_RD: conv_val <= rising_edge_latch;
              `ISCQ_CMD_FMASK_RD:  conv_val <= falling_edge_mask;
              `ISCQ_CMD_RMASK_RD:  conv_val <= rising_edge_mask;
              `ISCQ_CMD_ERR_POP:   conv_val <= (eq_cnt != 0) ?
                eq_mem[eq_rd] : `ISCQ_ERR_NONE; // R9
              default:             conv_val <= 16'h0000;
            endcase
            if (is_query(cmd_code)) begin
              state <= ST_CONV; // R5
            end else if (cmd_code == `ISCQ_CMD_OPC_Q) begin
              state <= ST_WAIT;
            end else if (cmd_code == `ISCQ_CMD_OUTPUT_ENABLE_COMMAND) begin
              output_enable_command_accept  <= (eq_cnt == 0); // R15
              output_enable_command_refused <= (eq_cnt != 0); // R15
            end
          end
        end
        ST_CONV: begin
          bcd      <= dadd(bcd, conv_val[15]);
          conv_val <= {conv_val[14:0], 1'b0};
          bit_cnt  <= bit_cnt + 1'b1;
          if (bit_cnt == 5'h0F) begin
            state <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (!rq_full && !rq_wr_en) begin // R24
            if (bcd[19:16] != 4'h0 || !lead || dig_idx == 3'h4) begin
              rq_wr_en   <= 1'b1;
              rq_wr_data <= `ISCQ_CHR_ZERO | {4'h0, bcd[19:16]};
              lead       <= 1'b0;
            end
            bcd     <= {bcd[15:0], 4'h0};
            dig_idx <= dig_idx + 1'b1;
            if (dig_idx == 3'h4) begin
              state <= ST_LF;
            end
          end
        end
        ST_WAIT: begin
          // Commands stay held off until the synced settle flag is high
          if (settle_s[1] && !rq_full) begin // R16
            rq_wr_en   <= 1'b1;
            rq_wr_data <= `ISCQ_CHR_ONE;
            state      <= ST_LF;
          end
        end
        ST_LF: begin
          if (!rq_full && !rq_wr_en) begin
            rq_wr_en   <= 1'b1;
            rq_wr_data <= `ISCQ_CHR_LF;
            state      <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  function [19:0] dadd;
    input [19:0] b;
    input        s;
    reg   [19:0] t;
    integer      i;
    begin
      t = b;
      for (i = 0; i < `ISCQ_DIGITS; i = i + 1) begin
        if (t[i*4 +: 4] > 4'h4) begin
          t[i*4 +: 4] = t[i*4 +: 4] + 4'h3;
        end
      end
      dadd = {t[18:0], s};
    end
  endfunction

  // Response queue pointers; memory read feeds the skid buffer
  always @(posedge mclk) begin
    if (!rstn) begin
      rq_wr   <= {`ISCQ_RQ_AW{1'b0}};
      rq_rd   <= {`ISCQ_RQ_AW{1'b0}};
      rq_cnt  <= {(`ISCQ_RQ_AW+1){1'b0}};
      mem_vld <= 1'b0;
    end else begin
      if (rq_wr_en) begin
        rq_wr <= rq_next(rq_wr); // R5
      end
      if (rq_pop && skid_ready) begin
        rq_rd <= rq_next(rq_rd); // R6
      end
      mem_vld <= rq_pop && skid_ready;
      rq_cnt <= rq_cnt + {{`ISCQ_RQ_AW{1'b0}}, rq_wr_en}
                - {{`ISCQ_RQ_AW{1'b0}}, (rq_pop && skid_ready)};
    end
  end

  iscq_mem #(
    .DW    (8),
    .AW    (`ISCQ_RQ_AW),
    .DEPTH (RQ_DEPTH)
  ) u_mem (
    .mclk    (mclk),
    .wr_en   (rq_wr_en),
    .wr_addr (rq_wr),
    .wr_data (rq_wr_data),
    .rd_addr (rq_rd),
    .rd_data (rq_rd_data)
  );

  // Skid keeps a fetched character when the bus stalls
  iscq_skid #(
    .DW (8)
  ) u_skid (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (mem_vld),
    .in_ready  (skid_ready),
    .in_data   (rq_rd_data),
    .out_valid (reply_valid), // R6
    .out_ready (reply_ready),
    .out_data  (reply_data)
  );

  // Status byte
  always @(posedge mclk) begin
    if (!rstn) begin
      status_byte <= 8'h00;
      rqs         <= 1'b0;
    end else begin
      status_byte <= 8'h00;
      status_byte[`ISCQ_STB_SUMMARY] <= change_hit; // R21
      status_byte[`ISCQ_STB_FAULT]   <= (eq_cnt != 0); // R10 R11
      status_byte[`ISCQ_STB_MAV]     <= (rq_cnt != 0) || reply_valid
                                        || mem_vld; // R7
      status_byte[`ISCQ_STB_EVENT]   <= event_summary;
      status_byte[`ISCQ_STB_RQS]     <= rqs; // R17
      rqs <= !clr && |(status_byte & srq_enable & `ISCQ_RQS_MASK); // R4 R17
    end
  end
endmodule

// ### dv/iscq_monitor.sv
/*
  Checker for the status and queue unit: port-level timing relations.
  Assumes it is bound to iscq_top and sees only the top module's ports.
*/
`timescale 1ns/10ps
`include "iscq_regs.vh"
module iscq_monitor (
  // Clock and reset
  input logic        mclk,
  input logic        rstn,
  // Command port
  input logic        cmd_valid,
  input logic        cmd_ready,
  input logic [3:0]  cmd_code,
  // Errors and replies
  input logic        err_valid,
  input logic        reply_valid,
  input logic        reply_ready,
  input logic [7:0]  reply_data,
  // Outcome and status
  input logic        output_enable_command_accept,
  input logic        output_enable_command_refused,
  input logic [7:0]  status_byte,
  input logic        service_request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  wire take      = cmd_valid && cmd_ready;
  wire output_enable_command_take = take && cmd_code == `ISCQ_CMD_OUTPUT_ENABLE_COMMAND;

  reply_hold_a: assert property (
    reply_valid && !reply_ready |=> reply_valid && $stable(reply_data))
    else $error("reply character changed before it was taken");
  srq_mirror_a: assert property (
    service_request == status_byte[`ISCQ_STB_RQS])
    else $error("service request differs from status bit 6");
  output_enable_command_excl_a: assert property (!(output_enable_command_accept && output_enable_command_refused))
    else $error("output enable both accepted and refused");
  output_enable_command_refuse_a: assert property (
    output_enable_command_take && status_byte[`ISCQ_STB_FAULT] && !$past(take)
    |=> output_enable_command_refused && !output_enable_command_accept)
    else $error("output enable not refused with errors queued");
  output_enable_command_grant_a: assert property (
    output_enable_command_take && !status_byte[`ISCQ_STB_FAULT] && !$past(err_valid)
    |=> output_enable_command_accept)
    else $error("output enable refused with empty error queue");
  output_enable_command_cause_a: assert property (
    output_enable_command_accept || output_enable_command_refused |-> $past(output_enable_command_take))
    else $error("output enable outcome without a command");
  query_busy_a: assert property (
    take && cmd_code == `ISCQ_CMD_STATE_RD |=> !cmd_ready [*8])
    else $error("new command accepted while a query runs");
  fault_raise_a: assert property (
    err_valid |-> ##2 status_byte[`ISCQ_STB_FAULT])
    else $error("fault pending bit missing after an error");
  cls_clear_a: assert property (
    take && cmd_code == `ISCQ_CMD_CLS
    |-> ##[1:3] !status_byte[`ISCQ_STB_FAULT])
    else $error("fault pending bit stays after clear status");
endmodule

bind iscq_top iscq_monitor u_mon (
  .mclk, .rstn, .cmd_valid, .cmd_ready, .cmd_code, .err_valid,
  .reply_valid, .reply_ready, .reply_data, .output_enable_command_accept, .output_enable_command_refused,
  .status_byte, .service_request
);

// ### dv/iscq_ctl_model.sv
/*
  Bus controller model: drains reply characters into a queue.
  Assumes the bench sets stall or slow pacing and pops rxq itself.
*/
`timescale 1ns/10ps
module iscq_ctl_model (
  // Clock
  input  wire       mclk,
  // Reply stream
  input  wire       reply_valid,
  input  wire [7:0] reply_data,
  output logic      reply_ready,
  // Pacing from the bench
  input  wire       stall,
  input  wire       slow
);
  logic [7:0] rxq[$];
  logic       phase = 1'b0;

  initial reply_ready = 1'b0;
  // Ready only moves just after an edge so a character is never half taken
  always @(posedge mclk) begin
    if (reply_valid && reply_ready)
      rxq.push_back(reply_data);
    phase <= ~phase;
    reply_ready <= #1 !stall && (!slow || phase);
  end
endmodule

// ### dv/status_error_queue_reporting_tb_top.sv
/*
  Self-checking bench for the status and queue unit.
  Assumes iscq_top, the controller model and the bound checker.
*/
`timescale 1ns/10ps
`include "iscq_regs.vh"
module status_error_queue_reporting_tb_top;
  logic        mclk      = 1'b0;
  logic        rstn      = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [3:0]  cmd_code  = 4'h0;
  logic [15:0] cmd_value = 16'h0000;
  logic        err_valid = 1'b0;
  logic [15:0] err_code  = 16'h0000;
  logic [15:0] icw       = 16'h0000;
  logic        settled   = 1'b1;
  logic [7:0]  srq_en    = 8'h04;
  logic        evs       = 1'b0;
  logic        stall     = 1'b0;
  logic        slow      = 1'b0;
  wire         cmd_ready, reply_valid, reply_ready, output_enable_command_accept;
  wire         output_enable_command_refused, service_request;
  wire  [7:0]  reply_data, status_byte;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          i;

  initial forever #2 mclk = ~mclk;

  iscq_top dut (
    .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_value(cmd_value),
    .err_valid(err_valid), .err_code(err_code),
    .instrument_condition_word(icw), .output_settled(settled),
    .srq_enable(srq_en), .event_summary(evs),
    .reply_valid(reply_valid), .reply_ready(reply_ready),
    .reply_data(reply_data), .output_enable_command_accept(output_enable_command_accept),
    .output_enable_command_refused(output_enable_command_refused), .status_byte(status_byte),
    .service_request(service_request)
  );

  iscq_ctl_model ctl (
    .mclk(mclk), .reply_valid(reply_valid), .reply_data(reply_data),
    .reply_ready(reply_ready), .stall(stall), .slow(slow)
  );

  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Holds the command until the edge that takes it
  task automatic send(input logic [3:0] c, input logic [15:0] d);
    int n;
    n = 0;
    // An edge passes first so back-to-back calls keep valid low for at least one edge between commands
    tick(1);
    while (cmd_ready !== 1'b1) begin
      tick(1);
      if (++n > 2000) begin
        num_errors++;
        summarize();
      end
    end
    cmd_code = c;
    cmd_value = d;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
  endtask

  // Reads one decimal reply up to its line feed
  task automatic get(input logic [31:0] exp);
    int n;
    logic [7:0]  ch;
    logic [31:0] v;
    n = 0;
    v = 0;
    ch = 8'h00;
    while (ch !== `ISCQ_CHR_LF) begin
      if (ctl.rxq.size() == 0) begin
        tick(1);
        if (++n > 2000) begin
          num_errors++;
          summarize();
        end
      end else begin
        ch = ctl.rxq.pop_front();
        if (ch !== `ISCQ_CHR_LF)
          v = v * 10 + (ch - `ISCQ_CHR_ZERO);
      end
    end
    check(v, exp);
  endtask

  task automatic q(input logic [3:0] c, input logic [31:0] exp);
    send(c, 16'h0000);
    get(exp);
  endtask

  task automatic errs(input logic [15:0] base, input int n);
    for (int k = 0; k < n; k++) begin
      err_code = base + k[15:0];
      err_valid = 1'b1;
      tick(1);
    end
    err_valid = 1'b0;
    tick(3);
  endtask

  initial begin
    tick(4);
    rstn = 1'b1;
    check(status_byte, 8'h00);
    q(`ISCQ_CMD_RMASK_RD, 0);
    send(`ISCQ_CMD_RMASK_WR, 16'h1000);
    q(`ISCQ_CMD_RMASK_RD, 4096);
    send(`ISCQ_CMD_FMASK_WR, 16'hFFFF);
    q(`ISCQ_CMD_FMASK_RD, 65535);
    icw = 16'h1001;
    tick(8);
    check(status_byte[2], 1'b1);
    check(service_request, 1'b1);
    q(`ISCQ_CMD_RLATCH_RD, 4097);
    q(`ISCQ_CMD_RLATCH_RD, 0);
    tick(4);
    check(status_byte[2], 1'b0);
    q(`ISCQ_CMD_STATE_RD, 4097);
    icw = 16'h0001;
    tick(8);
    check(status_byte[2], 1'b1);
    q(`ISCQ_CMD_FLATCH_RD, 4096);
    q(`ISCQ_CMD_FLATCH_RD, 0);
    evs = 1'b1;
    srq_en = 8'h20;
    tick(4);
    check(status_byte, 8'h60);
    srq_en = 8'h04;
    tick(4);
    check(service_request, 1'b0);
    evs = 1'b0;
    // Two replies wait behind a stalled reader
    stall = 1'b1;
    send(`ISCQ_CMD_STATE_RD, 16'h0000);
    send(`ISCQ_CMD_RMASK_RD, 16'h0000);
    tick(60);
    check(status_byte[4], 1'b1);
    stall = 1'b0;
    slow = 1'b1;
    get(1);
    get(4096);
    tick(6);
    check(status_byte[4], 1'b0);
    slow = 1'b0;
    errs(16'h0064, 3);
    check(status_byte, 8'h08);
    send(`ISCQ_CMD_OUTPUT_ENABLE_COMMAND, 16'h0000);
    check(output_enable_command_refused, 1'b1);
    for (i = 0; i < 3; i++)
      q(`ISCQ_CMD_ERR_POP, 100 + i);
    q(`ISCQ_CMD_ERR_POP, 0);
    send(`ISCQ_CMD_OUTPUT_ENABLE_COMMAND, 16'h0000);
    check(output_enable_command_accept, 1'b1);
    errs(16'h00C8, 20);
    for (i = 0; i < 15; i++)
      q(`ISCQ_CMD_ERR_POP, 200 + i);
    q(`ISCQ_CMD_ERR_POP, `ISCQ_ERR_OVERFLOW);
    q(`ISCQ_CMD_ERR_POP, 0);
    errs(16'h0005, 2);
    icw = 16'h1001;
    tick(8);
    send(`ISCQ_CMD_CLS, 16'h0000);
    tick(4);
    check(status_byte, 8'h00);
    q(`ISCQ_CMD_ERR_POP, 0);
    q(`ISCQ_CMD_RLATCH_RD, 0);
    settled = 1'b0;
    tick(3);
    send(`ISCQ_CMD_OPC_Q, 16'h0000);
    tick(50);
    check(ctl.rxq.size(), 0);
    settled = 1'b1;
    get(1);
    summarize();
  end
endmodule
